/* pkg/umc_pkg.sv */
// Package for the USB module control and error-status block.
// Assumes a 32-bit Avalon-MM register bus with word addresses given as byte offsets.
package umc_pkg;
  localparam logic [7:0] UMC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] UMC_OFS_ERR_STAT = 8'h04;
  localparam logic [7:0] UMC_OFS_ERR_CLR = 8'h08;
  localparam logic [7:0] UMC_OFS_ERR_EN = 8'h0C;
  localparam logic [7:0] UMC_OFS_TOKEN = 8'h10;
  localparam int UMC_BIT_JLEVEL = 7;
  localparam int UMC_BIT_SE0 = 6;
  localparam int UMC_BIT_INHIBIT = 5;
  localparam int UMC_BIT_BUSRST = 4;
  localparam int UMC_BIT_HOST_CAPABILITY_ENABLE = 3;
  localparam int UMC_BIT_RESUME = 2;
  localparam int UMC_BIT_PPCLR = 1;
  localparam int UMC_BIT_MODEN = 0;
  localparam int UMC_ERR_PID = 0;
  localparam int UMC_ERR_CRC_EOF = 1;
  localparam int UMC_ERR_DMA = 2;
  localparam int UMC_ERR_TURN = 3;
  localparam int UMC_ERR_W = 4;
  localparam logic [7:0] UMC_CTRL_RESET = 8'h00;
  localparam int UMC_CLK_HZ = 20000000;
  localparam int UMC_BIT_RATE_HZ = 12000000;
  localparam int UMC_TURN_BITS = 16;
  // Cycles for 16 bit times at full speed, longest time rounded down.
  localparam int UMC_TURN_CYC = (UMC_TURN_BITS * UMC_CLK_HZ) / UMC_BIT_RATE_HZ;
  localparam int UMC_LS_EOP_NS = 1330;
  localparam int UMC_LS_EOP_CYC = (UMC_LS_EOP_NS * (UMC_CLK_HZ / 1000000) + 999) / 1000;
  typedef enum logic [1:0] {
    UMC_RES_IDLE = 2'b00,
    UMC_RES_DRIVE = 2'b01,
    UMC_RES_EOP = 2'b11
  } umc_res_e;
endpackage

/* rtl/umc_turn_timer.sv */
// Idle timer that flags a bus turnaround timeout.
// Assumes eop and activity are synchronous one-cycle or level indications.
`timescale 1ns/100ps
module umc_turn_timer
  import umc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic armed_rst,
  input wire logic eop,
  input wire logic activity,
  output logic timeout
);
  typedef struct packed {
    logic armed;
    logic [7:0] cnt;
    logic flag;
  } umc_turn_s;
  umc_turn_s st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.flag = 1'b0;
    if (eop) begin
      nxt_st.armed = 1'b1;
      nxt_st.cnt = 8'h00;
    end else if (activity || armed_rst) begin
      nxt_st.armed = 1'b0;
    end else if (st_ff.armed) begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
      if (st_ff.cnt == 8'(UMC_TURN_CYC)) begin
        nxt_st.flag = 1'b1; // R16
        nxt_st.armed = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign timeout = st_ff.flag;
endmodule

/* rtl/umc_resume_gen.sv */
// Resume signalling generator with low-speed end-of-packet tail in host mode.
// Assumes resume_en is the software control bit, held for the required time by software.
`timescale 1ns/100ps
module umc_resume_gen
  import umc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic resume_en,
  input wire logic host_mode,
  output logic drive_k,
  output logic drive_se0
);
  typedef struct packed {
    umc_res_e state;
    logic [7:0] cnt;
  } umc_res_s;
  umc_res_s st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.state)
      UMC_RES_IDLE: begin
        if (resume_en) begin
          nxt_st.state = UMC_RES_DRIVE;
        end
      end
      UMC_RES_DRIVE: begin
        if (!resume_en) begin
          if (host_mode) begin
            nxt_st.state = UMC_RES_EOP; // R11
            nxt_st.cnt = 8'h00;
          end else begin
            nxt_st.state = UMC_RES_IDLE;
          end
        end
      end
      UMC_RES_EOP: begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
        if (st_ff.cnt == 8'(UMC_LS_EOP_CYC - 1)) begin
          nxt_st.state = UMC_RES_IDLE;
        end
      end
      default: begin
        nxt_st.state = UMC_RES_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign drive_k = (st_ff.state == UMC_RES_DRIVE); // R09
  assign drive_se0 = (st_ff.state == UMC_RES_EOP);
endmodule

/* rtl/umc_top.sv */
// USB module control register, error status and interrupt logic.
// Assumes an Avalon-MM master on clk_sys and line/engine status synchronous to clk_sys.
//
// Functional notes
// R01 - Control bit 7 shows live J state, read only.
// R02 - Control bit 6 shows live single-ended zero, read only.
// R03 - Device mode: bit 5 inhibits processing, set automatically on SETUP token.
// R04 - Host mode: bit 5 reads 1 while a token executes.
// R05 - Software checks token busy before writing a new token command.
// R06 - Host mode: bit 4 written 1 drives bus reset, 0 ends it.
// R07 - Bit 3 enables host capability; resets to 0.
// R08 - Any change of host enable resets all host control logic.
// R09 - Bit 2 high drives resume signalling; low drives none in device mode.
// R10 - Software holds resume 10 ms as function, 25 ms as host.
// R11 - Host mode: clearing resume appends a low-speed end-of-packet.
// R12 - Device mode: error bit 1 flags token CRC5 rejection.
// R13 - Host mode: error bit 1 flags end-of-frame error at frame counter zero.
// R14 - Error bit 0 flags a failed packet identifier check.
// R15 - Flag DMA error on late grant overflow/underflow or truncated packet.
// R16 - Flag turnaround timeout after more than 16 idle bit times.
// R17 - Control bits 31 to 8 read zero and ignore writes.
// R18 - Error flags stay set until software clears them.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module umc_top
  import umc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic line_j,
  input wire logic line_se0,
  input wire logic setup_token_rx,
  input wire logic token_done,
  input wire logic token_crc5_bad,
  input wire logic pid_check_bad,
  input wire logic frame_count_zero,
  input wire logic link_active,
  input wire logic dma_late,
  input wire logic rx_truncated,
  input wire logic rx_eop,
  output logic packet_processing_inhibit,
  output logic token_in_progress,
  output logic bus_reset_drive,
  output logic host_capability_enable,
  output logic host_logic_reset,
  output logic resume_k_drive,
  output logic resume_se0_drive,
  output logic pingpong_pointer_clear,
  output logic module_enable,
  output logic token_start,
  output logic [7:0] token_command_register,
  output logic irq
);
  import umc_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic busy;
    logic [7:0] tok;
    logic tok_go;
    logic hrst;
    logic [UMC_ERR_W-1:0] err;
    logic [UMC_ERR_W-1:0] en;
    logic irq;
    logic ack;
    logic waitreq;
    logic [31:0] rdata;
    logic kdrv;
    logic se0drv;
  } umc_top_s;
  umc_top_s st_ff, nxt_st;
  logic res_k;
  logic res_se0;
  logic turn_to;
  logic host_mode;
  logic wr_lane0;
  logic [UMC_ERR_W-1:0] err_evt;
  logic [7:0] ctrl_view;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Submodules.
  umc_resume_gen u_resume (
    .clk_sys(clk_sys),
    .rst(rst),
    .resume_en(st_ff.ctrl[UMC_BIT_RESUME]),
    .host_mode(host_mode),
    .drive_k(res_k),
    .drive_se0(res_se0)
  );
  umc_turn_timer u_turn (
    .clk_sys(clk_sys),
    .rst(rst),
    .armed_rst(st_ff.hrst),
    .eop(rx_eop),
    .activity(link_active),
    .timeout(turn_to)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Combinational next state.
  assign host_mode = st_ff.ctrl[UMC_BIT_HOST_CAPABILITY_ENABLE];
  assign wr_lane0 = avs_write && avs_byteenable[0] && !st_ff.ack;
  always_comb begin
    err_evt = '0;
    err_evt[UMC_ERR_PID] = pid_check_bad; // R14
    err_evt[UMC_ERR_CRC_EOF] = host_mode ? (frame_count_zero && link_active) // R13
                                         : token_crc5_bad; // R12
    err_evt[UMC_ERR_DMA] = dma_late || rx_truncated; // R15
    err_evt[UMC_ERR_TURN] = turn_to; // R16
  end
  always_comb begin
    ctrl_view = st_ff.ctrl;
    ctrl_view[UMC_BIT_JLEVEL] = line_j; // R01
    ctrl_view[UMC_BIT_SE0] = line_se0; // R02
    if (host_mode) begin
      ctrl_view[UMC_BIT_INHIBIT] = st_ff.busy; // R04
    end
  end
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      UMC_OFS_CONTROL: rd_mux = {24'h00_0000, ctrl_view}; // R17
      UMC_OFS_ERR_STAT: rd_mux = {28'h000_0000, st_ff.err};
      UMC_OFS_ERR_EN: rd_mux = {28'h000_0000, st_ff.en};
      UMC_OFS_TOKEN: rd_mux = {24'h00_0000, st_ff.tok};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tok_go = 1'b0;
    nxt_st.hrst = 1'b0;
    nxt_st.ack = (avs_read || avs_write) && !st_ff.ack;
    nxt_st.waitreq = !nxt_st.ack;
    if (avs_read && !st_ff.ack) begin
      nxt_st.rdata = rd_mux;
    end
    if (wr_lane0 && avs_address == UMC_OFS_CONTROL) begin
      nxt_st.ctrl[5:0] = avs_writedata[5:0]; // R17
      if (avs_writedata[UMC_BIT_HOST_CAPABILITY_ENABLE] != st_ff.ctrl[UMC_BIT_HOST_CAPABILITY_ENABLE]) begin
        nxt_st.hrst = 1'b1; // R08
        nxt_st.busy = 1'b0;
      end
    end
    if (!host_mode && setup_token_rx) begin
      nxt_st.ctrl[UMC_BIT_INHIBIT] = 1'b1; // R03
    end
    if (!host_mode) begin
      nxt_st.ctrl[UMC_BIT_BUSRST] = 1'b0;
    end
    if (host_mode && token_done) begin
      nxt_st.busy = 1'b0;
    end
    if (wr_lane0 && avs_address == UMC_OFS_TOKEN && host_mode && !st_ff.busy) begin
      nxt_st.tok = avs_writedata[7:0]; // R05
      nxt_st.busy = 1'b1; // R04
      nxt_st.tok_go = 1'b1;
    end
    if (wr_lane0 && avs_address == UMC_OFS_ERR_EN) begin
      nxt_st.en = avs_writedata[UMC_ERR_W-1:0];
    end
    if (wr_lane0 && avs_address == UMC_OFS_ERR_CLR) begin
      nxt_st.err = st_ff.err & ~avs_writedata[UMC_ERR_W-1:0];
    end
    nxt_st.err = nxt_st.err | err_evt; // R18
    nxt_st.irq = |(nxt_st.err & nxt_st.en);
    nxt_st.kdrv = res_k; // R09
    nxt_st.se0drv = res_se0 || (host_mode && st_ff.ctrl[UMC_BIT_BUSRST]); // R06
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.ctrl <= UMC_CTRL_RESET; // R07
      st_ff.waitreq <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitreq;
  assign packet_processing_inhibit = st_ff.ctrl[UMC_BIT_INHIBIT];
  assign token_in_progress = st_ff.busy;
  assign bus_reset_drive = st_ff.se0drv;
  assign host_capability_enable = st_ff.ctrl[UMC_BIT_HOST_CAPABILITY_ENABLE]; // R07
  assign host_logic_reset = st_ff.hrst;
  assign resume_k_drive = st_ff.kdrv;
  assign resume_se0_drive = st_ff.se0drv;
  assign pingpong_pointer_clear = st_ff.ctrl[UMC_BIT_PPCLR];
  assign module_enable = st_ff.ctrl[UMC_BIT_MODEN];
  assign token_start = st_ff.tok_go;
  assign token_command_register = st_ff.tok;
  assign irq = st_ff.irq;
endmodule

/* verif/umc_far_model.sv */
// Far-side cable model: live line states, frame levels and one-cycle link events.
// Assumes the bench calls its tasks right after a rising edge of clk_sys.
`timescale 1ns/100ps
module umc_far_model (
  input wire logic clk_sys,
  output logic line_j,
  output logic line_se0,
  output logic [6:0] ev,
  output logic frame_count_zero,
  output logic link_active
);
  initial begin
    line_j = 1'b1;
    line_se0 = 1'b0;
    ev = 7'h00;
    frame_count_zero = 1'b0;
    link_active = 1'b0;
  end
  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev <= 7'h01 << k;
    @(posedge clk_sys);
    ev <= 7'h00;
  endtask
  task automatic lines(input logic j, input logic s, input logic fz, input logic la);
    @(posedge clk_sys);
    line_j <= j;
    line_se0 <= s;
    frame_count_zero <= fz;
    link_active <= la;
  endtask
endmodule

/* verif/umc_top_chk.sv */
// Port checker for umc_top.
// Assumes it is bound into umc_top and sees only its ports.
`timescale 1ns/100ps
module umc_top_chk
  import umc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic line_j,
  input wire logic line_se0,
  input wire logic setup_token_rx,
  input wire logic token_done,
  input wire logic token_in_progress,
  input wire logic packet_processing_inhibit,
  input wire logic bus_reset_drive,
  input wire logic host_capability_enable,
  input wire logic host_logic_reset,
  input wire logic resume_k_drive,
  input wire logic resume_se0_drive,
  input wire logic token_start
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_ctrl_ack;
    !avs_waitrequest && avs_read && avs_address == UMC_OFS_CONTROL;
  endsequence
  sequence s_lines_still;
    $stable(line_j) && $stable(line_se0);
  endsequence
  a_ctrl_upper: assert property (s_ctrl_ack |-> avs_readdata[31:8] == 24'h000000)
    else $error("control upper bits not zero");
  a_live_lines: assert property (s_ctrl_ack ##0 s_lines_still
    |-> avs_readdata[7:6] == {line_j, line_se0}) else $error("live line bits wrong");
  a_setup_inhibit: assert property (setup_token_rx && !host_capability_enable
    |-> ##[1:2] packet_processing_inhibit) else $error("inhibit not set by setup");
  a_start_busy: assert property (token_start |-> host_capability_enable ##[0:1]
    token_in_progress) else $error("token start without busy");
  a_busy_done: assert property (token_done && token_in_progress && host_capability_enable
    |-> ##[1:2] !token_in_progress) else $error("busy not cleared");
  a_dev_no_reset: assert property (!host_capability_enable && !$past(host_capability_enable)
    && !$past(host_capability_enable, 2) |-> !bus_reset_drive) else $error("reset in device");
  a_host_toggle: assert property ($changed(host_capability_enable)
    |-> ##[0:1] host_logic_reset) else $error("no host logic reset");
  a_reset_pulse: assert property (host_logic_reset |=> !host_logic_reset)
    else $error("host reset not one cycle");
  a_resume_tail: assert property ($fell(resume_k_drive) && host_capability_enable
    |-> ##[0:2] resume_se0_drive) else $error("no end of packet after resume");
endmodule
bind umc_top umc_top_chk i_chk (.clk_sys, .rst, .avs_address, .avs_read, .avs_readdata,
  .avs_waitrequest, .line_j, .line_se0, .setup_token_rx, .token_done, .token_in_progress,
  .packet_processing_inhibit, .bus_reset_drive, .host_capability_enable, .host_logic_reset,
  .resume_k_drive, .resume_se0_drive, .token_start);

/* verif/usb_module_control_status_bench.sv */
// Bench for umc_top: bus tasks, far-side events and expected register values.
// Assumes umc_far_model and the bound checker.
`timescale 1ns/100ps
module usb_module_control_status_bench;
  import umc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic [7:0] token_command_register;
  logic [6:0] ev;
  logic avs_waitrequest, line_j, line_se0, frame_count_zero, link_active, irq;
  logic packet_processing_inhibit, token_in_progress, bus_reset_drive, host_capability_enable;
  logic resume_k_drive, resume_se0_drive, pingpong_pointer_clear, module_enable;
  logic [31:0] eb [0:6] = '{32'h0, 32'h0, 32'h2, 32'h1, 32'h4, 32'h4, 32'h8};
  int n_fail = 0;
  int checks = 0;
  always #25 clk_sys = ~clk_sys;
  umc_far_model i_far (.clk_sys, .line_j, .line_se0, .ev, .frame_count_zero, .link_active);
  umc_top i_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .line_j, .line_se0,
    .setup_token_rx(ev[0]), .token_done(ev[1]), .token_crc5_bad(ev[2]), .pid_check_bad(ev[3]),
    .frame_count_zero, .link_active, .dma_late(ev[4]), .rx_truncated(ev[5]), .rx_eop(ev[6]),
    .packet_processing_inhibit, .token_in_progress, .bus_reset_drive, .host_capability_enable,
    .host_logic_reset(), .resume_k_drive, .resume_se0_drive, .pingpong_pointer_clear,
    .module_enable, .token_start(), .token_command_register, .irq);
  task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic settle();
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      $display("[ERR] %0t bus wait timed out", $time);
      n_fail++;
      results();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(UMC_OFS_CONTROL, 32'h00000080);
    i_far.lines(1'b0, 1'b1, 1'b0, 1'b0);
    rd(UMC_OFS_CONTROL, 32'h00000040);
    i_far.lines(1'b1, 1'b0, 1'b0, 1'b0);
    wr(UMC_OFS_CONTROL, 32'hFFFFFFE3);
    rd(UMC_OFS_CONTROL, 32'h000000A3);
    chb(module_enable, 1'b1);
    chb(pingpong_pointer_clear, 1'b1);
    wr(UMC_OFS_CONTROL, 32'h00000000);
    i_far.pulse(0);
    rd(UMC_OFS_CONTROL, 32'h000000A0);
    wr(UMC_OFS_TOKEN, 32'h0000005A);
    settle();
    chb(token_in_progress, 1'b0);
    wr(UMC_OFS_CONTROL, 32'h00000000);
    wr(UMC_OFS_ERR_EN, 32'h0000000F);
    for (int i = 2; i < 7; i++) begin
      i_far.pulse(i);
      repeat (30) @(posedge clk_sys);
      rd(UMC_OFS_ERR_STAT, eb[i]);
      chb(irq, 1'b1);
      wr(UMC_OFS_ERR_CLR, 32'h0000000F);
      rd(UMC_OFS_ERR_STAT, 32'h00000000);
      settle();
      chb(irq, 1'b0);
    end
    wr(UMC_OFS_ERR_EN, 32'h00000000);
    i_far.pulse(3);
    rd(UMC_OFS_ERR_STAT, 32'h00000001);
    settle();
    chb(irq, 1'b0);
    wr(UMC_OFS_ERR_EN, 32'h00000001);
    settle();
    chb(irq, 1'b1);
    wr(UMC_OFS_ERR_CLR, 32'h00000001);
    wr(8'h20, 32'h000000FF);
    rd(8'h20, 32'h00000000);
    wr(UMC_OFS_CONTROL, 32'h00000008);
    i_far.lines(1'b1, 1'b0, 1'b1, 1'b1);
    rd(UMC_OFS_ERR_STAT, 32'h00000002);
    i_far.lines(1'b1, 1'b0, 1'b0, 1'b0);
    wr(UMC_OFS_ERR_CLR, 32'h0000000F);
    rd(UMC_OFS_CONTROL, 32'h00000088);
    wr(UMC_OFS_TOKEN, 32'h0000005A);
    rd(UMC_OFS_CONTROL, 32'h000000A8);
    chk({24'h0, token_command_register}, 32'h0000005A);
    i_far.pulse(1);
    rd(UMC_OFS_CONTROL, 32'h00000088);
    wr(UMC_OFS_CONTROL, 32'h00000018);
    settle();
    chb(bus_reset_drive, 1'b1);
    wr(UMC_OFS_CONTROL, 32'h0000000C);
    settle();
    chb(bus_reset_drive, 1'b0);
    chb(resume_k_drive, 1'b1);
    repeat (20) @(posedge clk_sys);
    wr(UMC_OFS_CONTROL, 32'h00000008);
    settle();
    chb(resume_k_drive, 1'b0);
    chb(resume_se0_drive, 1'b1);
    repeat (30) @(negedge clk_sys);
    chb(resume_se0_drive, 1'b0);
    wr(UMC_OFS_TOKEN, 32'h0000003C);
    wr(UMC_OFS_CONTROL, 32'h00000000);
    settle();
    chb(token_in_progress, 1'b0);
    wr(UMC_OFS_CONTROL, 32'h00000004);
    settle();
    chb(resume_k_drive, 1'b1);
    wr(UMC_OFS_CONTROL, 32'h00000000);
    settle();
    chb(resume_se0_drive, 1'b0);
    results();
  end
endmodule
